// ### include/vmd_pkg.sv
// Shared constants and types of the vector multiply-accumulate datapath.
// Assumes the register files drive operands on the issue cycle.
package vmd_pkg;

	// ----------------------------------------
	// Widths and lane counts
	// ----------------------------------------
	localparam int WORD_W = 32;
	localparam int SRC_WORDS = 32;
	localparam int PERM_WORDS = 16;
	localparam int PERM_SEL_W = 5;
	localparam int LANE_W = 16;
	localparam int MPY_LANES = 32;
	localparam int ACC_LANES = 16;
	localparam int ACC_W = 48;
	localparam int WIDE_W = 80;
	localparam int WIDE_HI_W = 32;
	localparam int OUT_W = 16;
	localparam int FP_LANES = 8;
	localparam int UPS_AMT_W = 5;
	localparam int SHIFT_REG_W = 8;
	localparam int SHIFT_AMT_W = 7;
	localparam int RND_W = 3;

	// ----------------------------------------
	// Rounding mode encodings
	// ----------------------------------------
	localparam logic [RND_W-1:0] RND_TRUNC = 3'h0;
	localparam logic [RND_W-1:0] RND_CEIL = 3'h1;
	localparam logic [RND_W-1:0] RND_POS_INF = 3'h2;
	localparam logic [RND_W-1:0] RND_NEG_INF = 3'h3;
	localparam logic [RND_W-1:0] RND_SYM_INF = 3'h4;
	localparam logic [RND_W-1:0] RND_SYM_ZERO = 3'h5;
	localparam logic [RND_W-1:0] RND_CONV_EVEN = 3'h6;
	localparam logic [RND_W-1:0] RND_CONV_ODD = 3'h7;

	// ----------------------------------------
	// Constants of the number formats
	// ----------------------------------------
	localparam logic [LANE_W-1:0] FIX_ONE = 16'h0001;
	localparam logic [WORD_W-1:0] FP_ONE = 32'h3F80_0000;
	localparam logic [7:0] FP_BIAS = 8'h7F;
	localparam logic [7:0] FP_EXP_MAX = 8'hFF;

	// ----------------------------------------
	// Operation and control types
	// ----------------------------------------
	typedef enum logic [2:0] {OP_NONE, OP_MAC, OP_UPS, OP_SRS, OP_FMAC} vmd_op_t;
	typedef enum logic [1:0] {YMX_COEF, YMX_RIGHT, YMX_ONE, YMX_SEXT} vmd_ymx_t;
	typedef enum logic [1:0] {ACM_ACC, ACM_UPS, ACM_CASC} vmd_acm_t;

	typedef struct packed {
		vmd_op_t op;
		logic pre_sub;
		logic pre_swap;
		vmd_ymx_t second_operand_mux;
		logic ymx_swap;
		logic psb_reduce;
		vmd_acm_t addend_source_mux;
		logic acc_sub;
		logic ups_hi;
		logic [UPS_AMT_W-1:0] ups_amt;
		logic srs_wide;
		logic fp_one;
		logic [FP_LANES-1:0] fp_neg;
		logic fp_add_vec;
	} vmd_ctl_t;

	localparam vmd_ctl_t CTL_IDLE = '0;

endpackage : vmd_pkg

// ### include/vmd_perm_if.sv
// Carrier between the datapath and one permuter instance.
// Assumes vmd_pkg is compiled first.
`timescale 1ns/1ns
interface vmd_perm_if;
	logic [vmd_pkg::SRC_WORDS*vmd_pkg::WORD_W-1:0] words;
	logic [vmd_pkg::PERM_WORDS*vmd_pkg::PERM_SEL_W-1:0] sel;
	logic [vmd_pkg::PERM_WORDS*vmd_pkg::WORD_W-1:0] perm_q;
	modport perm (input words, input sel, output perm_q);
	modport user (output words, output sel, input perm_q);
endinterface : vmd_perm_if

// ### rtl/vmd_permuter.sv
// Word permuter: each output word picks any source word, registered.
// Assumes select and source words are stable on the issue cycle.
`timescale 1ns/1ns
module vmd_permuter (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Source, select and permuted words
	vmd_perm_if.perm p
);
	localparam int W = vmd_pkg::WORD_W;
	localparam int N = vmd_pkg::PERM_WORDS;
	localparam int S = vmd_pkg::PERM_SEL_W;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			p.perm_q <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				p.perm_q[i*W +: W] <= p.words[int'(p.sel[i*S +: S])*W +: W];
			end
		end
	end
endmodule : vmd_permuter

// ### rtl/vmd_datapath.sv
// Vector datapath: fixed multiply, upshift, shift-round-saturate, float MAC.
// Assumes register files and cascade input are driven on this clock.
`timescale 1ns/1ns
module vmd_datapath (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Instruction issue
	input wire logic issue_i,
	input wire vmd_pkg::vmd_ctl_t ctl_i,
	input wire logic [vmd_pkg::PERM_WORDS*vmd_pkg::PERM_SEL_W-1:0] perm_l_sel_i,
	input wire logic [vmd_pkg::PERM_WORDS*vmd_pkg::PERM_SEL_W-1:0] perm_r_sel_i,
	input wire logic [vmd_pkg::PERM_WORDS*vmd_pkg::PERM_SEL_W-1:0] perm_c_sel_i,
	// Register file and stream reads
	input wire logic [vmd_pkg::SRC_WORDS*vmd_pkg::WORD_W-1:0] vec_a_i,
	input wire logic [vmd_pkg::SRC_WORDS*vmd_pkg::WORD_W-1:0] vec_c_i,
	input wire logic [vmd_pkg::MPY_LANES*vmd_pkg::LANE_W-1:0] ups_src_i,
	input wire logic [vmd_pkg::ACC_LANES*vmd_pkg::ACC_W-1:0] casc_i,
	input wire logic [vmd_pkg::ACC_LANES*vmd_pkg::ACC_W-1:0] srs_acc_i,
	input wire logic [vmd_pkg::SHIFT_REG_W-1:0] shift_reg_i,
	input wire logic [vmd_pkg::RND_W-1:0] rnd_mode_i,
	input wire logic [vmd_pkg::FP_LANES*vmd_pkg::WORD_W-1:0] fp_addend_i,
	// Accumulator result
	output logic [vmd_pkg::ACC_LANES*vmd_pkg::ACC_W-1:0] acc_o,
	output logic acc_valid_o,
	// Saturated vector result and memory store
	output logic [vmd_pkg::ACC_LANES*vmd_pkg::OUT_W-1:0] vec_wr_o,
	output logic vec_wr_valid_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [vmd_pkg::ACC_LANES*vmd_pkg::OUT_W-1:0] mem_wdata_o,
	// Float result
	output logic [vmd_pkg::FP_LANES*vmd_pkg::WORD_W-1:0] fp_o,
	output logic fp_valid_o
);
	localparam int L = vmd_pkg::LANE_W;
	localparam int A = vmd_pkg::ACC_W;
	localparam int W = vmd_pkg::WORD_W;
	localparam int ML = vmd_pkg::MPY_LANES;
	localparam int AL = vmd_pkg::ACC_LANES;
	localparam int HL = vmd_pkg::ACC_LANES / 2;
	localparam int FL = vmd_pkg::FP_LANES;
	localparam int O = vmd_pkg::OUT_W;
	localparam int WW = vmd_pkg::WIDE_W;

	// ----------------------------------------
	// Float helpers
	// ----------------------------------------
	// Denormals flush to zero and results truncate; no exceptions are raised.
	function automatic logic [W-1:0] fp_mul(input logic [W-1:0] a, input logic [W-1:0] b);
		logic [47:0] m;
		int e;
		logic [W-1:0] res;
		m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
		e = int'(a[30:23]) + int'(b[30:23]) - int'(vmd_pkg::FP_BIAS);
		if (m[47]) begin
			m = m >> 1;
			e = e + 1;
		end
		if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e <= 0) begin
			res = {a[31] ^ b[31], 31'h0};
		end else if (e >= int'(vmd_pkg::FP_EXP_MAX)) begin
			res = {a[31] ^ b[31], vmd_pkg::FP_EXP_MAX, 23'h0};
		end else begin
			res = {a[31] ^ b[31], 8'(e), m[45:23]};
		end
		return res;
	endfunction : fp_mul

	function automatic logic [W-1:0] fp_add(input logic [W-1:0] a, input logic [W-1:0] b);
		logic [W-1:0] x;
		logic [W-1:0] y;
		logic [W-1:0] res;
		logic [7:0] d;
		logic [26:0] mx;
		logic [26:0] my;
		logic [27:0] s;
		int e;
		if (a[30:0] >= b[30:0]) begin
			x = a;
			y = b;
		end else begin
			x = b;
			y = a;
		end
		mx = (x[30:23] == 8'h00) ? '0 : {1'b1, x[22:0], 3'h0};
		my = (y[30:23] == 8'h00) ? '0 : {1'b1, y[22:0], 3'h0};
		d = x[30:23] - y[30:23];
		my = (d > 8'h1A) ? '0 : (my >> d);
		s = (x[31] == y[31]) ? ({1'b0, mx} + {1'b0, my}) : ({1'b0, mx} - {1'b0, my});
		e = int'(x[30:23]);
		if (s[27]) begin
			s = s >> 1;
			e = e + 1;
		end
		for (int i = 0; i < 26; i++) begin
			if (s != '0 && !s[26]) begin
				s = s << 1;
				e = e - 1;
			end
		end
		if (s == '0 || e <= 0) begin
			res = '0;
		end else if (e >= int'(vmd_pkg::FP_EXP_MAX)) begin
			res = {x[31], vmd_pkg::FP_EXP_MAX, 23'h0};
		end else begin
			res = {x[31], 8'(e), s[25:3]};
		end
		return res;
	endfunction : fp_add

	// ----------------------------------------
	// Shift, round and saturate of one lane
	// ----------------------------------------
	function automatic logic [O-1:0] srs_lane(input logic signed [WW-1:0] v,
			input logic [vmd_pkg::SHIFT_AMT_W-1:0] sh, input logic [vmd_pkg::RND_W-1:0] mode);
		logic signed [WW-1:0] q;
		logic [WW-1:0] rem;
		logic [WW-1:0] half;
		logic gt;
		logic eq;
		logic up;
		logic [WW:0] r;
		logic [O-1:0] res;
		q = v >>> sh;
		rem = v & ((WW'(1) << sh) - WW'(1));
		half = (sh == '0) ? '0 : (WW'(1) << (sh - 1'b1));
		gt = rem > half;
		eq = rem == half;
		unique case (mode)
			vmd_pkg::RND_TRUNC: up = 1'b0;
			vmd_pkg::RND_CEIL: up = rem != '0;
			vmd_pkg::RND_POS_INF: up = gt | eq;
			vmd_pkg::RND_NEG_INF: up = gt;
			vmd_pkg::RND_SYM_INF: up = gt | (eq & ~v[WW-1]);
			vmd_pkg::RND_SYM_ZERO: up = gt | (eq & v[WW-1]);
			vmd_pkg::RND_CONV_EVEN: up = gt | (eq & q[0]);
			vmd_pkg::RND_CONV_ODD: up = gt | (eq & ~q[0]);
		endcase
		up = up & (sh != '0);
		r = {q[WW-1], q} + {{WW{1'b0}}, up};
		// Saturate when the bits above the result are not all sign
		if (&r[WW:O-1] || ~|r[WW:O-1]) begin
			res = r[O-1:0];
		end else begin
			res = r[WW] ? {1'b1, {(O-1){1'b0}}} : {1'b0, {(O-1){1'b1}}};
		end
		return res;
	endfunction : srs_lane

	// ----------------------------------------
	// Issue and control pipeline
	// ----------------------------------------
	vmd_pkg::vmd_ctl_t ctl_s;
	vmd_pkg::vmd_ctl_t ctl_q [1:6];

	// A single control word per cycle serves every path
	assign ctl_s = issue_i ? ctl_i : vmd_pkg::CTL_IDLE;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			for (int i = 1; i <= 6; i++) begin
				ctl_q[i] <= vmd_pkg::CTL_IDLE;
			end
		end else begin
			ctl_q[1] <= ctl_s;
			for (int i = 2; i <= 6; i++) begin
				ctl_q[i] <= ctl_q[i-1];
			end
		end
	end

	// ----------------------------------------
	// Permute network (E1)
	// ----------------------------------------
	vmd_perm_if pl ();
	vmd_perm_if pr ();
	vmd_perm_if pc ();

	assign pl.words = vec_a_i;
	assign pl.sel = perm_l_sel_i;
	// Right permuter held idle outside fixed multiplies to save toggling
	assign pr.words = (ctl_s.op == vmd_pkg::OP_MAC) ? vec_a_i : '0;
	assign pr.sel = perm_r_sel_i;
	assign pc.words = vec_c_i;
	assign pc.sel = perm_c_sel_i;

	vmd_permuter u_left_permuter (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .p(pl));
	vmd_permuter u_right_permuter (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .p(pr));
	vmd_permuter u_coefficient_permuter (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .p(pc));

	// ----------------------------------------
	// Pre-adder and second operand mux (E2)
	// ----------------------------------------
	logic signed [L:0] pre_q [ML];
	logic signed [L-1:0] y_q [ML];
	logic signed [2*L:0] prod_q [ML];

	always_ff @(posedge clk_sys_i) begin
		logic [L-1:0] lft;
		logic [L-1:0] rgt;
		logic [L-1:0] ysrc;
		if (!resetn_i) begin
			for (int i = 0; i < ML; i++) begin
				pre_q[i] <= '0;
				y_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < ML; i++) begin
				// Half swap covers the 32-bit permute granularity
				lft = pl.perm_q[(ctl_q[1].pre_swap ? (i ^ 1) : i)*L +: L];
				rgt = pr.perm_q[(ctl_q[1].pre_swap ? (i ^ 1) : i)*L +: L];
				pre_q[i] <= ctl_q[1].pre_sub ? ($signed({lft[L-1], lft}) - $signed({rgt[L-1], rgt}))
					: ($signed({lft[L-1], lft}) + $signed({rgt[L-1], rgt}));
				ysrc = pc.perm_q[(ctl_q[1].ymx_swap ? (i ^ 1) : i)*L +: L];
				unique case (ctl_q[1].second_operand_mux)
					vmd_pkg::YMX_COEF: y_q[i] <= ysrc;
					vmd_pkg::YMX_RIGHT: y_q[i] <= pr.perm_q[(ctl_q[1].ymx_swap ? (i ^ 1) : i)*L +: L];
					vmd_pkg::YMX_ONE: y_q[i] <= vmd_pkg::FIX_ONE;
					vmd_pkg::YMX_SEXT: y_q[i] <= {{(L/2){ysrc[L/2-1]}}, ysrc[L/2-1:0]};
				endcase
			end
		end
	end

	// ----------------------------------------
	// Multiplier array (E3)
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < ML; i++) begin
				prod_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < ML; i++) begin
				prod_q[i] <= pre_q[i] * y_q[i];
			end
		end
	end

	// ----------------------------------------
	// Post-adders (E4)
	// ----------------------------------------
	logic signed [A-1:0] psa_s [AL];
	logic signed [A-1:0] psb_q [AL];

	always_comb begin
		for (int j = 0; j < AL; j++) begin
			psa_s[j] = A'(prod_q[2*j]) + A'(prod_q[2*j+1]);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			for (int k = 0; k < AL; k++) begin
				psb_q[k] <= '0;
			end
		end else begin
			for (int k = 0; k < AL; k++) begin
				if (ctl_q[3].op != vmd_pkg::OP_MAC) begin
					psb_q[k] <= '0;
				end else if (!ctl_q[3].psb_reduce) begin
					psb_q[k] <= psa_s[k];
				end else begin
					psb_q[k] <= (k < HL) ? psa_s[(2*k) % AL] + psa_s[(2*k+1) % AL] : '0;
				end
			end
		end
	end

	// ----------------------------------------
	// Upshift path (E1 to E4)
	// ----------------------------------------
	logic signed [A-1:0] ups_q [1:4][AL];

	always_ff @(posedge clk_sys_i) begin
		logic [L-1:0] lane;
		if (!resetn_i) begin
			for (int s = 1; s <= 4; s++) begin
				for (int k = 0; k < AL; k++) begin
					ups_q[s][k] <= '0;
				end
			end
		end else begin
			for (int k = 0; k < AL; k++) begin
				lane = ups_src_i[(ctl_s.ups_hi ? k + AL : k)*L +: L];
				ups_q[1][k] <= A'($signed(lane)) <<< ctl_s.ups_amt;
				for (int s = 2; s <= 4; s++) begin
					ups_q[s][k] <= ups_q[s-1][k];
				end
			end
		end
	end

	// ----------------------------------------
	// Addend mux and summing adder (E5)
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		logic signed [A-1:0] addend;
		if (!resetn_i) begin
			acc_o <= '0;
			acc_valid_o <= 1'b0;
		end else begin
			acc_valid_o <= ctl_q[4].op == vmd_pkg::OP_MAC || ctl_q[4].op == vmd_pkg::OP_UPS;
			if (ctl_q[4].op == vmd_pkg::OP_MAC || ctl_q[4].op == vmd_pkg::OP_UPS) begin
				for (int k = 0; k < AL; k++) begin
					if (ctl_q[4].op == vmd_pkg::OP_UPS || ctl_q[4].addend_source_mux == vmd_pkg::ACM_UPS) begin
						addend = ups_q[4][k];
					end else if (ctl_q[4].addend_source_mux == vmd_pkg::ACM_CASC) begin
						addend = casc_i[k*A +: A];
					end else begin
						addend = acc_o[k*A +: A];
					end
					acc_o[k*A +: A] <= ctl_q[4].acc_sub ? addend - psb_q[k] : addend + psb_q[k];
				end
			end
		end
	end

	// ----------------------------------------
	// Shift-round-saturate path (E1 to E6)
	// ----------------------------------------
	logic [AL*A-1:0] srs_acc_q;
	logic [vmd_pkg::SHIFT_REG_W-1:0] shift_q;
	logic [vmd_pkg::RND_W-1:0] rnd_q;
	logic [O-1:0] half_q [2][HL];
	logic ilv_q;
	logic [AL*O-1:0] st_q [1:2];
	logic st_v_q [1:2];

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			srs_acc_q <= '0;
			shift_q <= '0;
			rnd_q <= vmd_pkg::RND_TRUNC;
		end else if (ctl_s.op == vmd_pkg::OP_SRS) begin
			srs_acc_q <= srs_acc_i;
			shift_q <= shift_reg_i;
			rnd_q <= rnd_mode_i;
		end
	end

	// Low and high halves share one shift amount and mode
	always_ff @(posedge clk_sys_i) begin
		logic signed [WW-1:0] v;
		int b;
		if (!resetn_i) begin
			ilv_q <= 1'b0;
			for (int h = 0; h < 2; h++) begin
				for (int k = 0; k < HL; k++) begin
					half_q[h][k] <= '0;
				end
			end
		end else begin
			ilv_q <= shift_q[vmd_pkg::SHIFT_REG_W-1];
			for (int h = 0; h < 2; h++) begin
				for (int k = 0; k < HL; k++) begin
					b = h*HL + 2*k;
					if (!ctl_q[1].srs_wide) begin
						v = WW'($signed(srs_acc_q[(h*HL+k)*A +: A]));
					end else if (k < HL/2) begin
						v = {srs_acc_q[(b+1)*A +: vmd_pkg::WIDE_HI_W], srs_acc_q[b*A +: A]};
					end else begin
						v = '0;
					end
					half_q[h][k] <= srs_lane(v, shift_q[vmd_pkg::SHIFT_AMT_W-1:0], rnd_q);
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			vec_wr_o <= '0;
			vec_wr_valid_o <= 1'b0;
			mem_req_o <= 1'b0;
		end else begin
			vec_wr_valid_o <= ctl_q[2].op == vmd_pkg::OP_SRS;
			mem_req_o <= ctl_q[2].op == vmd_pkg::OP_SRS;
			for (int k = 0; k < HL; k++) begin
				// Result holds between writes for a late reader
				if (ctl_q[2].op == vmd_pkg::OP_SRS && ilv_q) begin
					vec_wr_o[(2*k)*O +: O] <= half_q[0][k];
					vec_wr_o[(2*k+1)*O +: O] <= half_q[1][k];
				end else if (ctl_q[2].op == vmd_pkg::OP_SRS) begin
					vec_wr_o[k*O +: O] <= half_q[0][k];
					vec_wr_o[(k+HL)*O +: O] <= half_q[1][k];
				end
			end
		end
	end

	// Store issued at E3 travels three stages before it lands
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			st_q[1] <= '0;
			st_q[2] <= '0;
			st_v_q[1] <= 1'b0;
			st_v_q[2] <= 1'b0;
			mem_wdata_o <= '0;
			mem_we_o <= 1'b0;
		end else begin
			st_q[1] <= vec_wr_o;
			st_v_q[1] <= mem_req_o;
			st_q[2] <= st_q[1];
			st_v_q[2] <= st_v_q[1];
			mem_wdata_o <= st_q[2];
			mem_we_o <= st_v_q[2];
		end
	end

	// ----------------------------------------
	// Float multiply-accumulate path (E2 to E7)
	// ----------------------------------------
	logic [W-1:0] fa_q [FL];
	logic [W-1:0] fb_q [FL];
	logic [W-1:0] fm_q [1:3][FL];
	logic [W-1:0] fn_q [FL];
	logic [W-1:0] fs_q [FL];
	logic [FL*W-1:0] fadd_q [1:5];

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			for (int k = 0; k < FL; k++) begin
				fa_q[k] <= '0;
				fb_q[k] <= '0;
				fn_q[k] <= '0;
				fs_q[k] <= '0;
				for (int s = 1; s <= 3; s++) begin
					fm_q[s][k] <= '0;
				end
			end
			for (int s = 1; s <= 5; s++) begin
				fadd_q[s] <= '0;
			end
		end else begin
			fadd_q[1] <= fp_addend_i;
			for (int s = 2; s <= 5; s++) begin
				fadd_q[s] <= fadd_q[s-1];
			end
			for (int k = 0; k < FL; k++) begin
				fa_q[k] <= pl.perm_q[k*W +: W];
				fb_q[k] <= ctl_q[1].fp_one ? vmd_pkg::FP_ONE : pc.perm_q[k*W +: W];
				// New operands every cycle, products three stages later
				fm_q[1][k] <= fp_mul(fa_q[k], fb_q[k]);
				fm_q[2][k] <= fm_q[1][k];
				fm_q[3][k] <= fm_q[2][k];
				fn_q[k] <= {fm_q[3][k][W-1] ^ ctl_q[5].fp_neg[k], fm_q[3][k][W-2:0]};
				// Addend is zero or the matching lane of another vector
				fs_q[k] <= ctl_q[5].fp_add_vec ? fadd_q[5][k*W +: W] : '0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			fp_o <= '0;
			fp_valid_o <= 1'b0;
		end else begin
			fp_valid_o <= ctl_q[6].op == vmd_pkg::OP_FMAC;
			for (int k = 0; k < FL; k++) begin
				fp_o[k*W +: W] <= fp_add(fn_q[k], fs_q[k]);
			end
		end
	end
endmodule : vmd_datapath

// ### testbench/vmd_properties.sv
// Port timing checker of vmd_datapath.
// Assumes vmd_pkg compiled first; bound into every vmd_datapath.
`timescale 1ns/1ns
module vmd_properties (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// Issue
	input wire logic issue_i,
	input wire vmd_pkg::vmd_ctl_t ctl_i,
	// Results
	input wire logic [767:0] acc_o,
	input wire logic acc_valid_o,
	input wire logic [255:0] vec_wr_o,
	input wire logic vec_wr_valid_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [255:0] mem_wdata_o,
	input wire logic fp_valid_o
);
	logic mac_iss;
	logic srs_iss;
	logic fp_iss;
	assign mac_iss = issue_i && ctl_i.op inside {vmd_pkg::OP_MAC, vmd_pkg::OP_UPS};
	assign srs_iss = issue_i && ctl_i.op == vmd_pkg::OP_SRS;
	assign fp_iss = issue_i && ctl_i.op == vmd_pkg::OP_FMAC;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	// Store must carry the word written three cycles before
	sequence s_store_lands;
		##3 mem_we_o ##0 mem_wdata_o == $past(vec_wr_o, 3);
	endsequence
	a_mac_latency: assert property (mac_iss |-> ##5 acc_valid_o)
		else $error("accumulator result late or missing");
	a_acc_cause: assert property (acc_valid_o |-> $past(mac_iss, 5))
		else $error("accumulator result without issue");
	a_acc_holds: assert property (!acc_valid_o |-> $stable(acc_o))
		else $error("accumulator changed without result");
	a_srs_latency: assert property (srs_iss |-> ##3 vec_wr_valid_o)
		else $error("saturated result late or missing");
	a_store_pair: assert property (vec_wr_valid_o == mem_req_o)
		else $error("store issue apart from vector write");
	a_store_lands: assert property (mem_req_o |-> s_store_lands)
		else $error("store did not land three cycles later");
	a_wr_holds: assert property (!vec_wr_valid_o |-> $stable(vec_wr_o))
		else $error("vector result changed without write");
	a_fp_latency: assert property (fp_iss |-> ##7 fp_valid_o)
		else $error("float result late or missing");
	a_fp_cause: assert property (fp_valid_o |-> $past(fp_iss, 7))
		else $error("float result without issue");
endmodule : vmd_properties
bind vmd_datapath vmd_properties u_vmd_properties (.clk_sys_i, .resetn_i, .issue_i, .ctl_i,
	.acc_o, .acc_valid_o, .vec_wr_o, .vec_wr_valid_o, .mem_req_o, .mem_we_o, .mem_wdata_o,
	.fp_valid_o);

// ### testbench/vmd_regfile_model.sv
// Register files, accumulator and cascade contents seen by the datapath.
// Assumes fixed contents; float_i swaps vec_a words to float 2.0.
`timescale 1ns/1ns
module vmd_regfile_model (
	// Content select
	input wire logic float_i,
	// Operand reads
	output logic [1023:0] vec_a_o,
	output logic [1023:0] vec_c_o,
	output logic [511:0] ups_src_o,
	output logic [767:0] casc_o,
	output logic [767:0] srs_acc_o,
	output logic [255:0] fp_addend_o
);
	// Ties, a fraction bit and saturation on both sides
	localparam logic [47:0] SRC [7] = '{48'hA, 48'hFFFF_FFFF_FFF6, 48'hE, 48'h6, 48'h9,
		48'h7FFF_FFFF_FFFF, 48'h8000_0000_0000};
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			vec_a_o[16*i+:16] = float_i ? (i[0] ? 16'h4000 : 16'h0) : 16'(i);
			vec_c_o[16*i+:16] = i[0] ? 16'h4040 : 16'h0;
		end
		for (int i = 0; i < 32; i++) begin
			ups_src_o[16*i+:16] = 16'hFFF0 + 16'(i);
		end
		for (int i = 0; i < 16; i++) begin
			casc_o[48*i+:48] = 48'h100;
			srs_acc_o[48*i+:48] = i < 7 ? SRC[i] : (i < 8 ? 48'h0 : 48'h190 + 48'(4 * (i - 8)));
		end
		for (int i = 0; i < 8; i++) begin
			fp_addend_o[32*i+:32] = vmd_pkg::FP_ONE;
		end
	end
endmodule : vmd_regfile_model

// ### testbench/test_vector_mac_datapath.sv
// Self-checking bench of the vector datapath: MAC, upshift, ROUND_AND_SATURATE_PATH, float.
// Assumes vmd_pkg, checker and register file model are compiled first.
`timescale 1ns/1ns
module test_vector_mac_datapath;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic issue_i = 1'b0;
	vmd_pkg::vmd_ctl_t ctl_i = vmd_pkg::CTL_IDLE;
	logic [79:0] perm_l_sel_i;
	logic [79:0] perm_r_sel_i;
	logic [79:0] perm_c_sel_i;
	logic [7:0] shift_reg_i = 8'h0;
	logic [2:0] rnd_mode_i = 3'h0;
	logic float_mode = 1'b0;
	logic [1023:0] vec_a;
	logic [1023:0] vec_c;
	logic [511:0] left_shift_unit;
	logic [767:0] casc;
	logic [767:0] srs_acc;
	logic [255:0] fp_add;
	logic [767:0] acc_o;
	logic acc_valid_o;
	logic [255:0] vec_wr_o;
	logic vec_wr_valid_o;
	logic mem_req_o;
	logic mem_we_o;
	logic [255:0] mem_wdata_o;
	logic [255:0] fp_o;
	logic fp_valid_o;
	int n_fail = 0;
	int samples_checked = 0;
	// Rows: rounding mode; columns: acc lanes 0..4 shifted right by two
	localparam int RND_EXP [8][5] = '{'{2, -3, 3, 1, 2}, '{3, -2, 4, 2, 3}, '{3, -2, 4, 2, 2},
		'{2, -3, 3, 1, 2}, '{3, -3, 4, 2, 2}, '{2, -2, 3, 1, 2}, '{2, -2, 4, 2, 2},
		'{3, -3, 3, 1, 2}};
	always #5 clk_sys_i = ~clk_sys_i;
	vmd_regfile_model u_vmd_regfile_model (.float_i(float_mode), .vec_a_o(vec_a), .vec_c_o(vec_c),
		.ups_src_o(left_shift_unit), .casc_o(casc), .srs_acc_o(srs_acc), .fp_addend_o(fp_add));
	vmd_datapath u_vmd_datapath (.clk_sys_i, .resetn_i, .issue_i, .ctl_i, .perm_l_sel_i,
		.perm_r_sel_i, .perm_c_sel_i, .vec_a_i(vec_a), .vec_c_i(vec_c), .ups_src_i(left_shift_unit),
		.casc_i(casc), .srs_acc_i(srs_acc), .shift_reg_i, .rnd_mode_i, .fp_addend_i(fp_add),
		.acc_o, .acc_valid_o, .vec_wr_o, .vec_wr_valid_o, .mem_req_o, .mem_we_o, .mem_wdata_o,
		.fp_o, .fp_valid_o);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk_val(input string what, input logic [47:0] exp, input logic [47:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val
	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		chk_val(what, {16'h0, exp}, {16'h0, got});
	endtask : chk_word
	task automatic issue(input vmd_pkg::vmd_ctl_t c, input logic [7:0] sh, input logic [2:0] rm);
		@(negedge clk_sys_i);
		issue_i = 1'b1;
		ctl_i = c;
		shift_reg_i = sh;
		rnd_mode_i = rm;
		float_mode = c.op == vmd_pkg::OP_FMAC;
	endtask : issue
	task automatic bubble;
		@(negedge clk_sys_i);
		issue_i = 1'b0;
		ctl_i = vmd_pkg::CTL_IDLE;
	endtask : bubble
	// Always steps one edge first, so back-to-back pulses are counted apart
	task automatic wait_valid(input int w);
		int n;
		logic [2:0] v;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
			v = {acc_valid_o, vec_wr_valid_o, fp_valid_o};
		end while (v[2-w] !== 1'b1 && n < 12);
		if (v[2-w] !== 1'b1) chk_val("valid wait", 48'h1, 48'h0);
	endtask : wait_valid
	function automatic logic [15:0] lo_exp(input int m, input int k);
		return k < 5 ? 16'(RND_EXP[m][k]) : (k == 5 ? 16'h7FFF : (k == 6 ? 16'h8000 : 16'h0));
	endfunction : lo_exp
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_mac;
		vmd_pkg::vmd_ctl_t c;
		logic [47:0] e;
		c = vmd_pkg::CTL_IDLE;
		c.op = vmd_pkg::OP_MAC;
		c.second_operand_mux = vmd_pkg::YMX_ONE;
		c.psb_reduce = 1'b1;
		issue(c, 8'h0, 3'h0);
		c.acc_sub = 1'b1;
		issue(c, 8'h0, 3'h0);
		c = '{op: vmd_pkg::OP_MAC, second_operand_mux: vmd_pkg::YMX_ONE, addend_source_mux: vmd_pkg::ACM_CASC, pre_sub: 1'b1,
			default: '0};
		issue(c, 8'h0, 3'h0);
		c = '{op: vmd_pkg::OP_MAC, second_operand_mux: vmd_pkg::YMX_COEF, addend_source_mux: vmd_pkg::ACM_ACC, ymx_swap: 1'b1,
			pre_swap: 1'b1, default: '0};
		issue(c, 8'h0, 3'h0);
		bubble();
		wait_valid(0);
		for (int k = 0; k < 16; k++) begin
			chk_val("mac", k < 8 ? 48'(32'h8C + 32'h20 * k) : 48'h0, acc_o[48*k+:48]);
		end
		wait_valid(0);
		for (int k = 0; k < 16; k++) begin
			chk_val("mac sub", 48'h0, acc_o[48*k+:48]);
		end
		wait_valid(0);
		for (int k = 0; k < 16; k++) begin
			chk_val("mac casc", 48'h140, acc_o[48*k+:48]);
		end
		wait_valid(0);
		for (int k = 0; k < 16; k++) begin
			e = 48'(32'h140 + (32'h22 + 32'h4 * k) * 32'h4040);
			chk_val("mac swap", e, acc_o[48*k+:48]);
		end
	endtask : t_mac
	task automatic t_ups;
		vmd_pkg::vmd_ctl_t c;
		c = vmd_pkg::CTL_IDLE;
		c.op = vmd_pkg::OP_UPS;
		c.ups_amt = 5'h4;
		issue(c, 8'h0, 3'h0);
		c.ups_hi = 1'b1;
		issue(c, 8'h0, 3'h0);
		bubble();
		wait_valid(0);
		for (int k = 0; k < 16; k++) begin
			chk_val("ups lo", 48'((k - 16) * 16), acc_o[48*k+:48]);
		end
		wait_valid(0);
		for (int k = 0; k < 16; k++) begin
			chk_val("ups hi", 48'(k * 16), acc_o[48*k+:48]);
		end
	endtask : t_ups
	task automatic t_srs;
		vmd_pkg::vmd_ctl_t c;
		logic [15:0] e;
		c = vmd_pkg::CTL_IDLE;
		c.op = vmd_pkg::OP_SRS;
		for (int m = 0; m < 10; m++) begin
			c.srs_wide = m == 9;
			issue(c, m == 8 ? 8'h82 : 8'h02, m < 8 ? 3'(m) : 3'h0);
			bubble();
			wait_valid(1);
			for (int k = 0; k < 8; k++) begin
				if (m < 8) begin
					chk_word("srs lo", lo_exp(m, k), vec_wr_o[16*k+:16]);
					chk_word("srs hi", 16'h64 + 16'(k), vec_wr_o[16*(8+k)+:16]);
				end else if (m == 8) begin
					chk_word("ilv lo", lo_exp(0, k), vec_wr_o[32*k+:16]);
					chk_word("ilv hi", 16'h64 + 16'(k), vec_wr_o[32*k+16+:16]);
				end else begin
					e = k % 2 ? 16'h7FFF : 16'h8000;
					chk_word("wide lo", k < 4 ? e : 16'h0, vec_wr_o[16*k+:16]);
					chk_word("wide hi", k < 4 ? 16'h7FFF : 16'h0, vec_wr_o[16*(8+k)+:16]);
				end
			end
		end
	endtask : t_srs
	task automatic t_fp;
		vmd_pkg::vmd_ctl_t c;
		c = '{op: vmd_pkg::OP_FMAC, second_operand_mux: vmd_pkg::YMX_COEF, addend_source_mux: vmd_pkg::ACM_ACC, fp_one: 1'b1,
			fp_neg: 8'hAA, fp_add_vec: 1'b1, default: '0};
		issue(vmd_pkg::CTL_IDLE, 8'h0, 3'h0);
		issue(c, 8'h0, 3'h0);
		c.fp_one = 1'b0;
		c.fp_neg = 8'h0;
		issue(c, 8'h0, 3'h0);
		c.fp_add_vec = 1'b0;
		issue(c, 8'h0, 3'h0);
		bubble();
		wait_valid(2);
		for (int k = 0; k < 8; k++) begin
			chk_word("fp neg", k % 2 ? 32'hBF80_0000 : 32'h4040_0000, fp_o[32*k+:32]);
		end
		wait_valid(2);
		for (int k = 0; k < 8; k++) begin
			chk_word("fp mac", 32'h40E0_0000, fp_o[32*k+:32]);
		end
		wait_valid(2);
		for (int k = 0; k < 8; k++) begin
			chk_word("fp zero", 32'h40C0_0000, fp_o[32*k+:32]);
		end
	endtask : t_fp
	task automatic finish_test;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test
	initial begin
		for (int i = 0; i < 16; i++) begin
			perm_l_sel_i[5*i+:5] = 5'(16 + i);
			perm_r_sel_i[5*i+:5] = 5'(i);
			perm_c_sel_i[5*i+:5] = 5'(i);
		end
		repeat (6) @(negedge clk_sys_i);
		resetn_i = 1'b1;
		t_mac();
		t_ups();
		t_srs();
		t_fp();
		repeat (8) @(negedge clk_sys_i);
		finish_test();
	end
	// Whole run is under a hundred cycles
	initial begin
		#20000;
		n_fail++;
		finish_test();
	end
endmodule : test_vector_mac_datapath
